// *** hdl/charge_mode_pkg.sv ***
/*
 * charge_mode_pkg: constants and enumerations for the charging port mode controller.
 * Assumes a single 10 MHz reference clock.
 */
package charge_mode_pkg;
	localparam int unsigned CLK_HZ = 10_000_000;
	// input filter time in microseconds and derived cycles
	localparam int unsigned FILTER_US = 100;
	localparam int unsigned FILTER_CYC = (FILTER_US * (CLK_HZ / 1_000_000) > 0) ?
		FILTER_US * (CLK_HZ / 1_000_000) : 1;
	// discharge time in microseconds
	localparam int unsigned DISCHARGE_US = 400;
	localparam int unsigned DISCHARGE_CYC = DISCHARGE_US * (CLK_HZ / 1_000_000);
	// split_bias_b trial time in microseconds
	localparam int unsigned TRIAL_US = 400;
	localparam int unsigned TRIAL_CYC = TRIAL_US * (CLK_HZ / 1_000_000);
	localparam int unsigned CNT_W = 16;
	// mode-select codes, order mode_select_1, mode_select_2, mode_select_3
	localparam logic [2:0] SEL_OFF = 3'h0;
	localparam logic [2:0] SEL_AUTO_PW = 3'h1;
	localparam logic [2:0] SEL_STD1 = 3'h2;
	localparam logic [2:0] SEL_AUTO = 3'h3;
	localparam logic [2:0] SEL_FIX_SHORT = 3'h4;
	localparam logic [2:0] SEL_FIX_SPLIT = 3'h5;
	localparam logic [2:0] SEL_STD1B = 3'h6;
	localparam logic [2:0] SEL_CDP = 3'h7;
	localparam logic [2:0] SEL_RESET = 3'h0;

	typedef enum logic [1:0] {
		SCH_NONE,
		SCH_SHORTED,
		SCH_SPLIT_A,
		SCH_SPLIT_B
	} scheme_t;

	typedef enum logic [2:0] {
		ST_INIT,
		ST_PASS,
		ST_FIXED,
		ST_AUTO_A,
		ST_AUTO_B,
		ST_AUTO_SHORT,
		ST_DISCHARGE
	} state_t;
endpackage : charge_mode_pkg

// *** hdl/charging_port_mode_control.sv ***
/*
 * charging_port_mode_control: mode decode, automatic scheme selection, discharge sequencing,
 * data-switch gating and open-drain flags of a USB charging port.
 * Assumes analog detectors deliver logic levels and the bias network follows o_scheme.
 */
`timescale 1ns/1ps
module charging_port_mode_control
	import charge_mode_pkg::*;
#(
	parameter int unsigned DISCHARGE_CYCLES = DISCHARGE_CYC,
	parameter int unsigned TRIAL_CYCLES = TRIAL_CYC
)(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_enable,
	input wire logic i_mode_select_1,
	input wire logic i_mode_select_2,
	input wire logic i_mode_select_3,
	input wire logic i_limit_select,
	input wire logic i_load_present,
	input wire logic i_over_temp,
	input wire logic i_current_limit,
	input wire logic i_high_current,
	input wire logic i_compliant_attach,
	input wire logic i_data_line_released,
	output logic o_power_on,
	output logic o_discharge,
	output logic o_data_switch_on,
	output logic [1:0] o_scheme,
	output logic o_limit_high,
	output logic o_load_detect_en,
	output logic o_status_n_o,
	output logic o_status_n_oe,
	output logic o_fault_n_o,
	output logic o_fault_n_oe
);

	// refuse timer lengths the counter cannot hold
	if (DISCHARGE_CYCLES < 1 || DISCHARGE_CYCLES >= (1 << CNT_W) ||
		TRIAL_CYCLES < 1 || TRIAL_CYCLES >= (1 << CNT_W))
	begin : g_bad_timer
		$error("timer parameters out of range");
	end

	localparam logic [CNT_W-1:0] DIS_LAST = CNT_W'(DISCHARGE_CYCLES - 1);
	localparam logic [CNT_W-1:0] TRIAL_LAST = CNT_W'(TRIAL_CYCLES - 1);
	localparam logic [CNT_W-1:0] FILT_LAST = CNT_W'(FILTER_CYC - 1);

	typedef struct packed {
		logic [4:0] sync1;
		logic [4:0] sync2;
		logic [4:0] cand;
		logic [CNT_W-1:0] filt_cnt;
		logic [2:0] sel;
		logic lim;
		logic en;
		state_t state;
		state_t after_dis;
		scheme_t scheme;
		logic [CNT_W-1:0] cnt;
		logic locked;
		logic power_on;
		logic discharge;
		logic sw_on;
		logic limit_high;
		logic ld_en;
		logic status_oe;
		logic fault_oe;
	} ctl_t;

	ctl_t q_r;
	ctl_t q_nxt;
	logic std_mode;
	logic [4:0] raw;

	assign raw = {i_enable, i_limit_select, i_mode_select_1, i_mode_select_2, i_mode_select_3};

	// ****************************************************************
	// mode decode
	// ****************************************************************
	always_comb
	begin
		std_mode = (q_r.sel == SEL_CDP) || (q_r.sel == SEL_STD1) || (q_r.sel == SEL_STD1B);
	end

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb
	begin
		q_nxt = q_r;
		q_nxt.sync1 = raw;
		q_nxt.sync2 = q_r.sync1;
		if (q_r.sync2 != q_r.cand)
		begin
			q_nxt.cand = q_r.sync2;
			q_nxt.filt_cnt = '0;
		end
		else if (q_r.filt_cnt == FILT_LAST)
		begin
			q_nxt.en = q_r.cand[4];
			q_nxt.lim = q_r.cand[3];
			q_nxt.sel = q_r.cand[2:0];
		end
		else
		begin
			q_nxt.filt_cnt = q_r.filt_cnt + 1'b1;
		end

		unique case (q_r.state)
			ST_INIT:
			begin
				q_nxt.state = ST_DISCHARGE;
				q_nxt.cnt = '0;
			end
			ST_DISCHARGE:
			begin
				if (q_r.cnt >= DIS_LAST && q_r.en && q_r.sel != SEL_OFF)
				begin
					// target follows the registered mode q_r.sel, not the one being accepted this cycle
					q_nxt.state = (q_r.sel == SEL_AUTO || q_r.sel == SEL_AUTO_PW) ?
						((q_r.after_dis == ST_AUTO_SHORT) ? ST_AUTO_SHORT : ST_AUTO_A) :
						(std_mode ? ST_PASS : ST_FIXED);
					q_nxt.cnt = '0;
				end
				else if (q_r.cnt < DIS_LAST)
				begin
					q_nxt.cnt = q_r.cnt + 1'b1;
				end
			end
			default:
			begin
			end
		endcase

		if (q_r.state != ST_INIT && q_r.state != ST_DISCHARGE)
		begin
			unique case (q_r.state)
				ST_AUTO_A:
				begin
					if (i_compliant_attach && !q_r.locked)
					begin
						q_nxt.state = ST_DISCHARGE;
						q_nxt.after_dis = ST_AUTO_SHORT;
						q_nxt.cnt = '0;
					end
					else if (i_high_current && !q_r.locked)
					begin
						q_nxt.state = ST_AUTO_B;
						q_nxt.cnt = '0;
					end
				end
				ST_AUTO_B:
				begin
					if (!i_high_current)
					begin
						q_nxt.state = ST_AUTO_A;
						q_nxt.locked = 1'b1;
					end
					else if (q_r.cnt < TRIAL_LAST)
					begin
						q_nxt.cnt = q_r.cnt + 1'b1;
					end
				end
				ST_AUTO_SHORT:
				begin
					if (i_data_line_released)
					begin
						q_nxt.state = ST_AUTO_A;
						q_nxt.locked = 1'b0;
					end
				end
				default:
				begin
				end
			endcase
		end

		// disable, SEL_OFF or a change into auto from pass or fixed restarts through discharge; other mode changes switch directly
		if (q_r.state != ST_INIT)
		begin
			if (!q_r.en || q_r.sel == SEL_OFF)
			begin
				q_nxt.state = ST_DISCHARGE;
				q_nxt.cnt = '0;
			end
			if (q_r.state != ST_DISCHARGE && q_nxt.state != ST_DISCHARGE)
			begin
				if (std_mode && q_r.state != ST_PASS)
				begin
					q_nxt.state = ST_PASS;
				end
				else if ((q_r.sel == SEL_FIX_SHORT || q_r.sel == SEL_FIX_SPLIT) &&
					q_r.state != ST_FIXED)
				begin
					q_nxt.state = ST_FIXED;
				end
				else if ((q_r.sel == SEL_AUTO || q_r.sel == SEL_AUTO_PW) &&
					(q_r.state == ST_PASS || q_r.state == ST_FIXED))
				begin
					q_nxt.state = ST_DISCHARGE;
					q_nxt.after_dis = ST_AUTO_A;
					q_nxt.locked = 1'b0;
					q_nxt.cnt = '0;
				end
			end
			if (q_nxt.state == ST_DISCHARGE && q_r.state != ST_DISCHARGE &&
				q_r.state != ST_AUTO_A)
			begin
				q_nxt.after_dis = (q_r.sel == SEL_AUTO || q_r.sel == SEL_AUTO_PW) ?
					ST_AUTO_A : (std_mode ? ST_PASS : ST_FIXED);
			end
			if (q_r.state == ST_DISCHARGE)
			begin
				q_nxt.after_dis = (q_r.sel == SEL_AUTO || q_r.sel == SEL_AUTO_PW) ?
					((q_r.after_dis == ST_AUTO_SHORT) ? ST_AUTO_SHORT : ST_AUTO_A) :
					(std_mode ? ST_PASS : ST_FIXED);
			end
		end

		// outputs from next state
		unique case (q_nxt.state)
			ST_PASS: q_nxt.scheme = SCH_NONE;
			ST_FIXED: q_nxt.scheme = (q_r.sel == SEL_FIX_SHORT) ? SCH_SHORTED : SCH_SPLIT_A;
			ST_AUTO_A: q_nxt.scheme = SCH_SPLIT_A;
			ST_AUTO_B: q_nxt.scheme = SCH_SPLIT_B;
			ST_AUTO_SHORT: q_nxt.scheme = SCH_SHORTED;
			default: q_nxt.scheme = SCH_NONE;
		endcase
		q_nxt.discharge = (q_nxt.state == ST_DISCHARGE) || (q_nxt.state == ST_INIT);
		q_nxt.power_on = !q_nxt.discharge && q_r.en;
		// current limit is not a term here
		q_nxt.sw_on = (q_nxt.state == ST_PASS) && q_r.en && std_mode;
		q_nxt.limit_high = q_r.lim || (q_r.sel == SEL_AUTO) || (q_r.sel == SEL_AUTO_PW);
		q_nxt.ld_en = q_r.lim && ((q_r.sel == SEL_CDP) || (q_r.sel == SEL_AUTO) ||
			(q_r.sel == SEL_AUTO_PW));
		q_nxt.status_oe = !(q_nxt.ld_en && i_load_present && !q_nxt.discharge);
		q_nxt.fault_oe = !(i_over_temp || i_current_limit);
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			q_r <= '{sync1: 5'h00, sync2: 5'h00, cand: 5'h00, filt_cnt: '0, sel: SEL_RESET,
				lim: 1'b0, en: 1'b0, state: ST_INIT, after_dis: ST_PASS, scheme: SCH_NONE,
				cnt: '0, locked: 1'b0, power_on: 1'b0, discharge: 1'b1, sw_on: 1'b0,
				limit_high: 1'b0, ld_en: 1'b0, status_oe: 1'b1, fault_oe: 1'b1};
		end
		else
		begin
			q_r <= q_nxt;
		end
	end

	assign o_power_on = q_r.power_on;
	assign o_discharge = q_r.discharge;
	assign o_data_switch_on = q_r.sw_on;
	assign o_scheme = q_r.scheme;
	assign o_limit_high = q_r.limit_high;
	assign o_load_detect_en = q_r.ld_en;
	assign o_status_n_o = 1'b0;
	assign o_status_n_oe = q_r.status_oe;
	assign o_fault_n_o = 1'b0;
	assign o_fault_n_oe = q_r.fault_oe;

	// ****************************************************************
	// checks
	// ****************************************************************
	disable_off_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		!q_r.en |=> !o_data_switch_on && !o_power_on)
		else $error("enable low left switches on");
	fault_flag_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_over_temp || i_current_limit) |=> !o_fault_n_oe)
		else $error("fault flag not asserted");
	status_flag_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		!o_status_n_oe |-> o_load_detect_en && !o_discharge)
		else $error("status flag without load detection");
	switch_discharge_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		o_discharge |-> !o_data_switch_on && !o_power_on)
		else $error("switch on during discharge");
	switch_dedicated_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		o_scheme != SCH_NONE |-> !o_data_switch_on)
		else $error("switch on in dedicated mode");
	attach_discharge_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(q_r.state == ST_AUTO_A && i_compliant_attach && !q_r.locked && q_r.en &&
		q_r.sel == SEL_AUTO && q_nxt.state == ST_DISCHARGE) |=> o_discharge ##1 o_discharge)
		else $error("attach did not discharge");
	short_release_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(q_r.state == ST_AUTO_SHORT && i_data_line_released && q_nxt.state == ST_AUTO_A)
		|=> o_scheme == SCH_SPLIT_A)
		else $error("release did not return to split_a");
	high_current_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(q_r.state == ST_AUTO_A && q_nxt.state == ST_AUTO_B) |=> o_scheme == SCH_SPLIT_B)
		else $error("high current did not try split_b");
	fixed_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(q_r.state == ST_FIXED && $stable(q_r.sel)) |=> $stable(o_scheme) || o_scheme == SCH_NONE)
		else $error("fixed scheme changed");
	short_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(q_r.state == ST_AUTO_SHORT && !i_data_line_released && q_r.en && q_r.sel == SEL_AUTO)
		|=> o_scheme == SCH_SHORTED)
		else $error("shorted scheme left early");
	limit_switch_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(o_data_switch_on && i_current_limit && q_r.state == ST_PASS && q_r.en && std_mode)
		|=> o_data_switch_on)
		else $error("current limit opened switches");
	switch_pass_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(o_scheme == SCH_NONE && o_power_on)
		|-> o_data_switch_on)
		else $error("switch open in pass-through");
	repower_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(q_r.state == ST_DISCHARGE && q_nxt.state != ST_DISCHARGE)
		|=> o_power_on && !o_discharge)
		else $error("power not restored after discharge");
	filter_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		!(q_r.sync2 == q_r.cand && q_r.filt_cnt == FILT_LAST)
		|=> $stable(q_r.sel) && $stable(q_r.en) && $stable(q_r.lim))
		else $error("control change passed the filter early");
endmodule : charging_port_mode_control

// *** tb/portable_device_model.sv ***
/*
 * portable_device_model: behavioural portable device on the far side of the charging port.
 * Assumes the bench commands attach and current draw; the port drives scheme and power.
 */
`timescale 1ns/1ps
module portable_device_model
	import charge_mode_pkg::*;
(
	input wire logic [1:0] i_scheme,
	input wire logic i_power_on,
	input wire logic i_want_attach,
	input wire logic i_draw_high,
	input wire logic i_keep_b,
	output logic o_compliant_attach,
	output logic o_data_line_released,
	output logic o_high_current
);
	// ****************************************
	// detection and charging behaviour
	// ****************************************
	// device probes the data lines and reports a compliant attach
	assign o_compliant_attach = i_want_attach;
	assign o_data_line_released = !i_want_attach;
	// high draw in split_a; in split_b only if it still charges fast
	assign o_high_current = i_draw_high && i_power_on &&
		(i_scheme == SCH_SPLIT_A || (i_scheme == SCH_SPLIT_B && i_keep_b));
endmodule : portable_device_model

// *** tb/tb_charging_port_mode_control.sv ***
/*
 * tb_charging_port_mode_control: self-checking bench for the charging port mode controller.
 * Assumes a 10 MHz clock, short discharge and trial counts, and the portable device model.
 */
`timescale 1ns/1ps
module tb_charging_port_mode_control
	import charge_mode_pkg::*;
;
	logic i_ref_clk = 1'b0;
	logic i_rst = 1'b1;
	logic en = 1'b0;
	logic [2:0] sel = 3'h0;
	logic lim = 1'b0;
	logic load = 1'b0;
	logic hot = 1'b0;
	logic ilim = 1'b0;
	logic want = 1'b0;
	logic draw = 1'b0;
	logic keep = 1'b0;
	logic attach, released, high;
	logic pwr, dis, sw, lhi, lden, st_o, st_oe, f_o, f_oe;
	logic [1:0] sch;
	int dis_seen = 0;
	int mark = 0;
	int err_total = 0;
	int comparisons = 0;

	always #50 i_ref_clk = ~i_ref_clk;

	charging_port_mode_control #(.DISCHARGE_CYCLES(4), .TRIAL_CYCLES(4)) dut_u (
		.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_enable(en),
		.i_mode_select_1(sel[2]), .i_mode_select_2(sel[1]), .i_mode_select_3(sel[0]),
		.i_limit_select(lim), .i_load_present(load), .i_over_temp(hot),
		.i_current_limit(ilim), .i_high_current(high), .i_compliant_attach(attach),
		.i_data_line_released(released), .o_power_on(pwr), .o_discharge(dis),
		.o_data_switch_on(sw), .o_scheme(sch), .o_limit_high(lhi), .o_load_detect_en(lden),
		.o_status_n_o(st_o), .o_status_n_oe(st_oe), .o_fault_n_o(f_o), .o_fault_n_oe(f_oe));

	portable_device_model dev_u (.i_scheme(sch), .i_power_on(pwr), .i_want_attach(want),
		.i_draw_high(draw), .i_keep_b(keep), .o_compliant_attach(attach),
		.o_data_line_released(released), .o_high_current(high));

	// ****************************************
	// helpers
	// ****************************************
	task check(input logic [1:0] seen, input logic [1:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error at %0t: got %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	task end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test

	task tick(input int n);
		repeat (n) @(posedge i_ref_clk);
		#10;
	endtask : tick

	task set_mode(input logic e, input logic [2:0] code, input logic l);
		en = e;
		sel = code;
		lim = l;
	endtask : set_mode

	task wait_mode(input logic [1:0] want_sch);
		int n;
		n = 0;
		while (!(sch === want_sch && pwr === 1'b1 && dis === 1'b0) && n < 3000)
		begin
			tick(1);
			n++;
		end
		if (n >= 3000)
		begin
			err_total++;
			$display("Error at %0t: wait for scheme timed out", $time);
			end_of_test();
		end
	endtask : wait_mode

	// switches open and power off for the whole discharge
	always @(negedge i_ref_clk)
	begin
		if (!i_rst && dis === 1'b1)
		begin
			dis_seen++;
			check(sw, 2'h0);
			check(pwr, 2'h0);
		end
	end

	// ****************************************
	// test sequence
	// ****************************************
	initial
	begin
		tick(16);
		check({dis, pwr}, 2'h2);
		check({st_oe, f_oe}, 2'h3);
		i_rst = 1'b0;
		set_mode(1'b1, 3'h7, 1'b1);
		want = 1'b1;
		wait_mode(SCH_NONE);
		check(sw, 2'h1);
		check({lhi, lden}, 2'h3);
		check({st_o, f_o}, 2'h0);
		load = 1'b1;
		tick(3);
		check(st_oe, 2'h0);
		load = 1'b0;
		ilim = 1'b1;
		tick(3);
		check({f_oe, f_o}, 2'h0);
		check(sw, 2'h1);
		ilim = 1'b0;
		hot = 1'b1;
		tick(3);
		check(f_oe, 2'h0);
		hot = 1'b0;
		want = 1'b0;
		sel = 3'h0;
		tick(5);
		sel = 3'h7;
		tick(20);
		check(sw, 2'h1);
		$display("test pass_through done");
		mark = dis_seen;
		set_mode(1'b1, 3'h3, 1'b0);
		wait_mode(SCH_SPLIT_A);
		check(sw, 2'h0);
		check(dis_seen != mark, 2'h1);
		check({lhi, lden}, 2'h2);
		mark = dis_seen;
		want = 1'b1;
		wait_mode(SCH_SHORTED);
		check(dis_seen != mark, 2'h1);
		tick(20);
		check(sch, SCH_SHORTED);
		want = 1'b0;
		wait_mode(SCH_SPLIT_A);
		keep = 1'b1;
		draw = 1'b1;
		wait_mode(SCH_SPLIT_B);
		tick(20);
		check(sch, SCH_SPLIT_B);
		keep = 1'b0;
		wait_mode(SCH_SPLIT_A);
		tick(20);
		check(sch, SCH_SPLIT_A);
		draw = 1'b0;
		$display("test auto_select done");
		set_mode(1'b1, 3'h4, 1'b1);
		wait_mode(SCH_SHORTED);
		check(sw, 2'h0);
		set_mode(1'b1, 3'h5, 1'b1);
		wait_mode(SCH_SPLIT_A);
		tick(20);
		check(sch, SCH_SPLIT_A);
		$display("test fixed_scheme done");
		set_mode(1'b0, 3'h7, 1'b1);
		tick(1100);
		check({dis, pwr}, 2'h2);
		check(sw, 2'h0);
		set_mode(1'b1, 3'h0, 1'b0);
		tick(1100);
		check({dis, sw}, 2'h2);
		set_mode(1'b1, 3'h2, 1'b0);
		wait_mode(SCH_NONE);
		check(sw, 2'h1);
		check({lhi, lden}, 2'h0);
		$display("test disable done");
		i_rst = 1'b1;
		tick(2);
		check({dis, pwr}, 2'h2);
		check(sch, SCH_NONE);
		i_rst = 1'b0;
		tick(3);
		check({dis, sw}, 2'h2);
		$display("test reset done");
		end_of_test();
	end
endmodule : tb_charging_port_mode_control
